/* hw/txd_buf2.sv */
// Purpose: Small valid/ready buffer ahead of the decoder
// Assumes: DEPTH is a power of two, at least two
// Notes:   in_ready_o falls when full, so the source stalls
`timescale 1ns/100ps
module txd_buf2 #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 2
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic [WIDTH-1:0] in_data_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    output logic      [WIDTH-1:0] out_data_o,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];  // Storage
    logic [AW:0]      wr_r;         // Write pointer with wrap bit
    logic [AW:0]      rd_r;         // Read pointer with wrap bit
    logic             push;
    logic             pop;

    // Honest full and empty from pointer compare
    assign in_ready_o  = (wr_r - rd_r) != (AW+1)'(DEPTH);
    assign out_valid_o = wr_r != rd_r;
    assign out_data_o  = mem[rd_r[AW-1:0]];
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;

    // Storage write
    always_ff @(posedge clk_i) begin
        if (push) begin
            mem[wr_r[AW-1:0]] <= in_data_i;
        end
    end

    // Pointers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wr_r <= '0;
            rd_r <= '0;
        end else begin
            wr_r <= wr_r + (AW+1)'(push);
            rd_r <= rd_r + (AW+1)'(pop);
        end
    end
endmodule

/* hw/txd_ctl_decode.sv */
// Purpose: Decode transmit control words into buffer and next-pointer steps
// Assumes: Words arrive from fetch logic on clk_i; datapath takes cmd_* steps
// Notes:   One descriptor at a time; filter mode changes only on setup words
//
// The Wishbone register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/100ps
module txd_ctl_decode
    import txd_pkg::*;
#(
    parameter int BUF_DEPTH = 2
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic [31:0] desc_word_i,
    input  wire logic        desc_valid_i,
    output logic             desc_ready_o,
    output logic             cmd_valid_o,
    input  wire logic        cmd_ready_i,
    output cmd_kind_type     cmd_kind_o,
    output logic [LEN_W-1:0] cmd_len_o,
    output next_sel_type     next_sel_o,
    output logic             frame_crc_o,
    output logic             frame_pad_o,
    output filt_mode_type    filt_mode_o,
    output logic [4:0]       filt_exact_o,
    output logic             filt_hash_o,
    output logic             filt_inverse_o,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [3:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o
);
    typedef enum logic [2:0] {S_IDLE, S_BUF1, S_BUF2, S_SETUP, S_NEXT} state_type;

    state_type        state_r;    // Step being offered
    state_type        state_nxt;
    logic [31:0]      word_r;     // Descriptor being worked
    logic [31:0]      word_in;    // Head of the buffer
    logic             word_vld;   // Head valid
    logic             take;       // Head word accepted this cycle
    logic             step_done;  // Current step accepted downstream
    logic             enable;     // Software enable
    cmd_kind_type     kind_r;     // Offered step kind
    logic [LEN_W-1:0] len_r;      // Offered step length
    next_sel_type     sel_r;      // Next-descriptor choice
    logic             crc_r;      // Frame appends CRC
    logic             pad_r;      // Frame pads short (CRC set separately)
    filt_mode_type    filt_r;     // Current filter mode
    logic [31:0]      count_r;    // Descriptors taken
    logic             chain_w;    // Word under work is chained
    logic [LEN_W-1:0] len1_w;
    logic [LEN_W-1:0] len2_w;

    // Input buffer, stalls fetch once it is full while the decoder is busy
    txd_buf2 #(
        .WIDTH (32),
        .DEPTH (BUF_DEPTH)
    ) u_buf (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .in_data_i   (desc_word_i),
        .in_valid_i  (desc_valid_i),
        .in_ready_o  (desc_ready_o),
        .out_data_o  (word_in),
        .out_valid_o (word_vld),
        .out_ready_i (take)
    );

    // Register file
    txd_regs u_regs (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .wb_cyc_i (wb_cyc_i),
        .wb_stb_i (wb_stb_i),
        .wb_we_i  (wb_we_i),
        .wb_adr_i (wb_adr_i),
        .wb_sel_i (wb_sel_i),
        .wb_dat_i (wb_dat_i),
        .wb_dat_o (wb_dat_o),
        .wb_ack_o (wb_ack_o),
        .enable_o (enable),
        .status_i ({28'h0, state_r != S_IDLE, 1'b0, filt_r}),
        .count_i  (count_r),
        .last_i   (word_r)
    );

    // Handshake and outputs
    assign take        = word_vld && enable && state_r == S_IDLE;
    assign step_done   = cmd_valid_o && cmd_ready_i;
    assign cmd_valid_o = state_r != S_IDLE;
    assign cmd_kind_o  = kind_r;
    assign cmd_len_o   = len_r;
    assign next_sel_o  = sel_r;
    assign frame_crc_o = crc_r;
    assign frame_pad_o = pad_r;
    assign filt_mode_o = filt_r;
    assign chain_w     = word_r[BIT_CHAIN_NEXT];
    assign len1_w      = word_r[LEN1_MSB:LEN1_LSB];
    assign len2_w      = word_r[LEN2_MSB:LEN2_LSB];

    // Step sequencing
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            S_IDLE: begin
                if (take && word_in[BIT_CONFIG]) begin
                    state_nxt = S_SETUP;
                end else if (take && word_in[LEN1_MSB:LEN1_LSB] != '0) begin
                    state_nxt = S_BUF1;
                end else if (take && !word_in[BIT_CHAIN_NEXT]
                             && word_in[LEN2_MSB:LEN2_LSB] != '0) begin
                    state_nxt = S_BUF2;
                end else if (take) begin
                    state_nxt = S_NEXT;
                end
            end
            S_BUF1: begin
                if (step_done && !chain_w && len2_w != '0) begin
                    state_nxt = S_BUF2;
                end else if (step_done) begin
                    state_nxt = S_NEXT;
                end
            end
            S_BUF2, S_SETUP: begin
                if (step_done) begin
                    state_nxt = S_NEXT;
                end
            end
            S_NEXT: begin
                if (step_done) begin
                    state_nxt = S_IDLE;
                end
            end
        endcase
    end

    // State register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_r <= S_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Step kind and length, loaded only on a change of step so a stall holds them
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            kind_r <= CMD_NEXT;
            len_r  <= '0;
        end else if (state_nxt != state_r) begin
            unique case (state_nxt)
                S_BUF1: begin
                    kind_r <= CMD_BUF1;
                    len_r  <= word_in[LEN1_MSB:LEN1_LSB];
                end
                S_BUF2: begin
                    kind_r <= CMD_BUF2;
                    len_r  <= (state_r == S_IDLE) ? word_in[LEN2_MSB:LEN2_LSB] : len2_w;
                end
                S_SETUP: begin
                    kind_r <= CMD_SETUP;
                    len_r  <= word_in[LEN1_MSB:LEN1_LSB];
                end
                S_NEXT: begin
                    kind_r <= CMD_NEXT;
                    len_r  <= '0;
                end
                default: begin
                    kind_r <= kind_r;
                    len_r  <= len_r;
                end
            endcase
        end
    end

    // Descriptor capture, next choice and count
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            word_r  <= WORD_RST;
            sel_r   <= NEXT_SEQ;
            count_r <= '0;
        end else if (take) begin
            word_r  <= word_in;
            sel_r   <= next_sel_of(word_in);
            count_r <= count_r + 32'h1;
        end
    end

    // Per-frame CRC and pad settings, latched on the opening chunk
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            crc_r <= 1'b1;
            pad_r <= 1'b1;
        end else if (take && word_in[BIT_FIRST_CHUNK] && !word_in[BIT_CONFIG]) begin
            crc_r <= !word_in[BIT_CRC_INH];
            pad_r <= !word_in[BIT_PAD_INH];
        end
    end

    // Filter mode, changed only by setup words
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            filt_r <= FILT_PERFECT;
        // code from bits 28 and 22
        end else if (take && word_in[BIT_CONFIG]) begin
            filt_r <= filt_mode_type'({word_in[BIT_KIND_HIGH], word_in[BIT_KIND_LOW]});
        end
    end

    // Filter table shape per mode
    always_comb begin
        unique case (filt_r)
            FILT_PERFECT: begin
                filt_exact_o   = EXACT_TABLE;
                filt_hash_o    = 1'b0;
                filt_inverse_o = 1'b0;
            end
            FILT_HASH: begin
                filt_exact_o   = EXACT_ONE;
                filt_hash_o    = 1'b1;
                filt_inverse_o = 1'b0;
            end
            FILT_INVERSE: begin
                filt_exact_o   = EXACT_TABLE;
                filt_hash_o    = 1'b0;
                filt_inverse_o = 1'b1;
            end
            FILT_HASH_ONLY: begin
                filt_exact_o   = EXACT_NONE;
                filt_hash_o    = 1'b1;
                filt_inverse_o = 1'b0;
            end
        endcase
    end

    // Checks
    property p_setup_step;
        @(posedge clk_i) disable iff (rst_i)
        take && word_in[BIT_CONFIG] |=> cmd_valid_o && cmd_kind_o == CMD_SETUP;
    endproperty
    a_setup_step: assert property (p_setup_step) else $error("setup step missing");

    property p_crc_inh;
        @(posedge clk_i) disable iff (rst_i)
        take && word_in[BIT_FIRST_CHUNK] && !word_in[BIT_CONFIG] |=>
            frame_crc_o == !$past(word_in[BIT_CRC_INH]);
    endproperty
    a_crc_inh: assert property (p_crc_inh) else $error("crc setting wrong");

    property p_crc_later;
        @(posedge clk_i) disable iff (rst_i)
        take && !word_in[BIT_FIRST_CHUNK] |=> $stable(frame_crc_o) && $stable(frame_pad_o);
    endproperty
    a_crc_later: assert property (p_crc_later) else $error("crc changed mid frame");

    property p_ring;
        @(posedge clk_i) disable iff (rst_i)
        take && word_in[BIT_RING_WRAP] |=> next_sel_o == NEXT_BASE;
    endproperty
    a_ring: assert property (p_ring) else $error("ring wrap not taken");

    property p_chain;
        @(posedge clk_i) disable iff (rst_i)
        take && word_in[BIT_CHAIN_NEXT] && !word_in[BIT_RING_WRAP] |=>
            next_sel_o == NEXT_ADDR2;
    endproperty
    a_chain: assert property (p_chain) else $error("chain not taken");

    property p_pad;
        @(posedge clk_i) disable iff (rst_i)
        take && word_in[BIT_FIRST_CHUNK] && !word_in[BIT_CONFIG] |=>
            frame_pad_o == !$past(word_in[BIT_PAD_INH]);
    endproperty
    a_pad: assert property (p_pad) else $error("pad setting wrong");

    property p_chain_skip2;
        @(posedge clk_i) disable iff (rst_i)
        state_r == S_BUF1 && step_done && chain_w |=> cmd_kind_o == CMD_NEXT;
    endproperty
    a_chain_skip2: assert property (p_chain_skip2) else $error("chained buf2 used");

    property p_empty;
        @(posedge clk_i) disable iff (rst_i)
        take && !word_in[BIT_CONFIG] && word_in[LEN1_MSB:LEN1_LSB] == '0
            && (word_in[BIT_CHAIN_NEXT] || word_in[LEN2_MSB:LEN2_LSB] == '0)
            |=> cmd_kind_o == CMD_NEXT;
    endproperty
    a_empty: assert property (p_empty) else $error("empty buffers not skipped");

    property p_order;
        @(posedge clk_i) disable iff (rst_i)
        state_r == S_BUF1 && step_done && !chain_w && len2_w != '0 |=>
            cmd_kind_o == CMD_BUF2 && cmd_len_o == $past(len2_w);
    endproperty
    a_order: assert property (p_order) else $error("buffer order wrong");

    property p_filt_hold;
        @(posedge clk_i) disable iff (rst_i)
        take && !word_in[BIT_CONFIG] |=> $stable(filt_mode_o);
    endproperty
    a_filt_hold: assert property (p_filt_hold) else $error("filter changed");

    property p_inverse;
        @(posedge clk_i) disable iff (rst_i)
        take && word_in[BIT_CONFIG] && word_in[BIT_KIND_HIGH] && !word_in[BIT_KIND_LOW]
            |=> filt_inverse_o && filt_exact_o == EXACT_TABLE;
    endproperty
    a_inverse: assert property (p_inverse) else $error("inverse mode wrong");

    c_two_buf: cover property (@(posedge clk_i) disable iff (rst_i)
        cmd_kind_o == CMD_BUF1 && step_done ##1 cmd_kind_o == CMD_BUF2);
    c_setup: cover property (@(posedge clk_i) disable iff (rst_i)
        cmd_kind_o == CMD_SETUP && step_done);
    c_full: cover property (@(posedge clk_i) disable iff (rst_i)
        desc_valid_i && !desc_ready_o);
endmodule

/* hw/txd_pkg.sv */
// Purpose: Shared constants and types for transmit control word decode
// Assumes: 32-bit control words, 32-bit classic Wishbone register bus
// Notes:   Bit positions, offsets and reset values are named once here
package txd_pkg;
    // Control word field positions
    localparam int BIT_FIRST_CHUNK = 29;
    localparam int BIT_KIND_HIGH   = 28;
    localparam int BIT_CONFIG      = 27;
    localparam int BIT_CRC_INH     = 26;
    localparam int BIT_RING_WRAP   = 25;
    localparam int BIT_CHAIN_NEXT  = 24;
    localparam int BIT_PAD_INH     = 23;
    localparam int BIT_KIND_LOW    = 22;
    localparam int LEN2_MSB        = 21;
    localparam int LEN2_LSB        = 11;
    localparam int LEN1_MSB        = 10;
    localparam int LEN1_LSB        = 0;
    localparam int LEN_W           = 11;
    // Filter table sizes
    localparam logic [4:0] EXACT_TABLE = 5'h10;
    localparam logic [4:0] EXACT_ONE   = 5'h01;
    localparam logic [4:0] EXACT_NONE  = 5'h00;
    // Register byte offsets
    localparam logic [3:0] OFS_CTRL   = 4'h0;
    localparam logic [3:0] OFS_STATUS = 4'h4;
    localparam logic [3:0] OFS_COUNT  = 4'h8;
    localparam logic [3:0] OFS_LAST   = 4'hC;
    // Reset values
    localparam logic        CTRL_EN_RST = 1'b1;
    localparam logic [31:0] WORD_RST    = 32'h0000_0000;
    // Command kinds toward the transmit datapath
    typedef enum logic [1:0] {CMD_BUF1, CMD_BUF2, CMD_SETUP, CMD_NEXT} cmd_kind_type;
    // Where the next descriptor comes from
    typedef enum logic [1:0] {NEXT_SEQ, NEXT_BASE, NEXT_ADDR2} next_sel_type;
    // Address filter modes, encoded as the two-bit kind code
    typedef enum logic [1:0] {
        FILT_PERFECT = 2'h0, FILT_HASH = 2'h1, FILT_INVERSE = 2'h2, FILT_HASH_ONLY = 2'h3
    } filt_mode_type;

    // Next-descriptor choice; ring wrap beats chaining
    function automatic next_sel_type next_sel_of(input logic [31:0] w);
        if (w[BIT_RING_WRAP]) begin
            return NEXT_BASE;
        end else if (w[BIT_CHAIN_NEXT]) begin
            return NEXT_ADDR2;
        end
        return NEXT_SEQ;
    endfunction
endpackage

/* hw/txd_regs.sv */
// Purpose: Classic Wishbone slave holding control and status words
// Assumes: Single-cycle classic requests, 32-bit data
// Notes:   Ack one cycle after the request; unmapped reads give zero
`timescale 1ns/100ps
module txd_regs
    import txd_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [3:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    output logic             enable_o,
    input  wire logic [31:0] status_i,
    input  wire logic [31:0] count_i,
    input  wire logic [31:0] last_i
);
    logic        ack_r;  // Answer strobe
    logic        en_r;   // Decoder enable
    logic [31:0] dat_r;  // Read data

    assign wb_ack_o = ack_r;
    assign wb_dat_o = dat_r;
    assign enable_o = en_r;

    // Ack, dropped in the cycle after; read data follows the address every cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_r <= 1'b0;
            dat_r <= WORD_RST;
        end else begin
            ack_r <= wb_cyc_i && wb_stb_i && !ack_r;
            unique case (wb_adr_i)
                OFS_CTRL:   dat_r <= {31'h0, en_r};
                OFS_STATUS: dat_r <= status_i;
                OFS_COUNT:  dat_r <= count_i;
                OFS_LAST:   dat_r <= last_i;
                default:    dat_r <= WORD_RST;
            endcase
        end
    end

    // Write takes effect on the acking edge
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            en_r <= CTRL_EN_RST;
        end else if (ack_r && wb_we_i && wb_sel_i[0] && wb_adr_i == OFS_CTRL) begin
            en_r <= wb_dat_i[0];
        end
    end
endmodule

/* tb/test_txd_ctl_decode.sv */
// Purpose: Self-checking bench for the control word decoder
// Assumes: Host model feeds words and takes steps
// Notes:   Register access over classic Wishbone
`timescale 1ns/100ps
module test_txd_ctl_decode;
    import txd_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic stall = 1'b0;
    logic [31:0] desc_word;
    logic desc_valid, desc_ready, cmd_valid, cmd_ready;
    cmd_kind_type cmd_kind;
    logic [10:0] cmd_len;
    next_sel_type next_sel_o;
    filt_mode_type filt_mode_o;
    logic frame_crc_o, frame_pad_o, filt_hash_o, filt_inverse_o;
    logic [4:0] filt_exact_o;
    logic wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0, wb_ack;
    logic [3:0] wb_adr = 4'h0, wb_sel = 4'h0;
    logic [31:0] wb_wdat = 32'h0000_0000, wb_rdat, rd;
    int err_total = 0, n_checks = 0, sent = 0;
    always #2 clk_i = ~clk_i;
    txd_ctl_decode #(.BUF_DEPTH(2)) u_dut (.clk_i(clk_i), .rst_i(rst_i),
        .desc_word_i(desc_word), .desc_valid_i(desc_valid), .desc_ready_o(desc_ready),
        .cmd_valid_o(cmd_valid), .cmd_ready_i(cmd_ready), .cmd_kind_o(cmd_kind),
        .cmd_len_o(cmd_len), .next_sel_o(next_sel_o), .frame_crc_o(frame_crc_o),
        .frame_pad_o(frame_pad_o), .filt_mode_o(filt_mode_o), .filt_exact_o(filt_exact_o),
        .filt_hash_o(filt_hash_o), .filt_inverse_o(filt_inverse_o), .wb_cyc_i(wb_cyc),
        .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel),
        .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack));
    txd_host_model u_host (.clk_i(clk_i), .rst_i(rst_i), .stall_i(stall),
        .desc_word_o(desc_word), .desc_valid_o(desc_valid), .desc_ready_i(desc_ready),
        .cmd_valid_i(cmd_valid), .cmd_ready_o(cmd_ready), .cmd_kind_i(cmd_kind),
        .cmd_len_i(cmd_len));
    // Compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks=%0d errors=%0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // One classic Wishbone cycle, held until ack
    task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_i);
        wb_cyc <= 1'b1; wb_stb <= 1'b1; wb_we <= we; wb_adr <= a; wb_sel <= 4'hF;
        wb_wdat <= d;
        // Wait for the answer; only the watchdog ends a hang
        do begin
            @(posedge clk_i);
        end while (wb_ack !== 1'b1);
        rd = wb_rdat;
        wb_cyc <= 1'b0; wb_stb <= 1'b0; wb_we <= 1'b0;
        @(posedge clk_i);
        chk(32'(wb_ack), 32'h0); // ack lasts one cycle
    endtask
    task automatic wait_steps(input int n);
        int k;
        for (k = 0; k < 200 && u_host.steps.size() < n; k++) @(posedge clk_i);
        repeat (3) @(posedge clk_i);
    endtask
    // Push one word, expect its step list and next choice
    task automatic run_word(input logic [31:0] w);
        logic [12:0] e[$];
        if (w[BIT_CONFIG]) e.push_back({CMD_SETUP, w[10:0]});
        else begin
            if (w[10:0] != 11'h000) e.push_back({CMD_BUF1, w[10:0]});
            if (!w[24] && w[21:11] != 11'h000) e.push_back({CMD_BUF2, w[21:11]});
        end
        e.push_back({CMD_NEXT, 11'h000});
        u_host.steps.delete();
        u_host.push(w);
        sent++;
        wait_steps(e.size());
        chk(32'(u_host.steps.size()), 32'(e.size()));
        foreach (e[i]) chk(32'(u_host.steps[i]), 32'(e[i]));
        chk(32'(next_sel_o), w[25] ? 32'(NEXT_BASE) : w[24] ? 32'(NEXT_ADDR2) : 32'(NEXT_SEQ));
    endtask
    task automatic t_reset;
        chk({desc_ready, cmd_valid, frame_crc_o, frame_pad_o, wb_ack}, 32'h16);
        chk({filt_mode_o, filt_exact_o, filt_hash_o, filt_inverse_o}, 32'h040);
        $display("test reset done");
    endtask
    task automatic t_buffers;
        logic [31:0] tbl[7] = '{32'h0000_3805, 32'h0000_3800, 32'h0000_0005,
            32'h0100_3805, 32'h0200_3805, 32'h0300_3805, 32'h003F_FFFF};
        foreach (tbl[i]) begin
            stall <= i[0];
            run_word(tbl[i]);
        end
        $display("test buffers done");
    endtask
    task automatic t_setup;
        logic [6:0] ex[4] = '{7'h40, 7'h06, 7'h41, 7'h02};
        for (int c = 0; c < 4; c++) begin
            run_word(32'h0800_00C0 | (32'(c[1]) << 28) | (32'(c[0]) << 22));
            chk({filt_mode_o, filt_exact_o, filt_hash_o, filt_inverse_o}, {c[1:0], ex[c]});
        end
        run_word(32'h1040_0005);
        chk(32'(filt_mode_o), 32'(FILT_HASH_ONLY));
        run_word(32'h1000_0805);
        chk(32'(filt_mode_o), 32'(FILT_HASH_ONLY));
        $display("test setup done");
    endtask
    task automatic t_frame;
        run_word(32'h2480_0005);
        chk({frame_crc_o, frame_pad_o}, 32'h0);
        run_word(32'h0000_0005);
        chk({frame_crc_o, frame_pad_o}, 32'h0);
        run_word(32'h2400_0005);
        chk({frame_crc_o, frame_pad_o}, 32'h1);
        run_word(32'h2000_0005);
        chk({frame_crc_o, frame_pad_o}, 32'h3);
        $display("test frame done");
    endtask
    // Stop decoding, fill the buffer, then drain with a stalling sink
    task automatic t_fill;
        stall <= 1'b1;
        wb(1'b1, OFS_CTRL, 32'h0);
        u_host.steps.delete();
        for (int i = 3; i < 6; i++) u_host.push(32'h0000_0800 | i);
        sent += 3;
        repeat (10) @(posedge clk_i);
        chk({desc_valid, desc_ready, cmd_valid}, 32'h4);
        wb(1'b0, 4'h2, 32'h0);
        chk(rd, 32'h0);
        wb(1'b0, OFS_CTRL, 32'h0);
        chk(rd, 32'h0);
        wb(1'b1, OFS_CTRL, 32'h1);
        wait_steps(9);
        chk(32'(u_host.steps.size()), 32'h9);
        foreach (u_host.steps[i]) chk(32'(u_host.steps[i]), i % 3 == 0 ? 32'(i / 3 + 3) :
            i % 3 == 1 ? 32'h801 : 32'h1800);
        wb(1'b0, OFS_COUNT, 32'h0);
        chk(rd, 32'(sent));
        wb(1'b0, OFS_LAST, 32'h0);
        chk(rd, 32'h0000_0805);
        wb(1'b0, OFS_STATUS, 32'h0);
        chk(rd & 32'hB, 32'(FILT_HASH_ONLY));
        $display("test fill done");
    endtask
    initial begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        t_reset();
        t_buffers();
        t_setup();
        t_frame();
        t_fill();
        tally_and_finish();
    end
    // Watchdog against a hang
    initial begin
        #80000;
        err_total++;
        tally_and_finish();
    end
endmodule

/* tb/txd_host_model.sv */
// Purpose: Far-side model: descriptor word source and step sink
// Assumes: Same clock as the decoder; words queued by the bench
// Notes:   Sink can stall every other cycle to test holding
`timescale 1ns/100ps
module txd_host_model
    import txd_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        stall_i,
    output logic      [31:0] desc_word_o,
    output logic             desc_valid_o,
    input  wire logic        desc_ready_i,
    input  wire logic        cmd_valid_i,
    output logic             cmd_ready_o,
    input  cmd_kind_type     cmd_kind_i,
    input  wire logic [10:0] cmd_len_i
);
    logic [31:0] q[$];     // Words waiting to be offered
    logic [12:0] steps[$]; // Taken steps, kind and length
    // Queue a word off the sampling edge
    task automatic push(input logic [31:0] w);
        @(negedge clk_i);
        q.push_back(w);
    endtask
    // Source: hold word until taken; idle line toggles
    always @(posedge clk_i) begin
        if (rst_i) begin
            desc_valid_o <= 1'b0;
            desc_word_o  <= 32'h0000_0000;
        end else begin
            if (desc_valid_o && desc_ready_i) void'(q.pop_front());
            if (q.size() > 0) begin
                desc_valid_o <= 1'b1;
                desc_word_o <= q[0];
            end else begin
                desc_valid_o <= 1'b0;
                desc_word_o <= ~desc_word_o;
            end
        end
    end
    // Sink: record each taken step, stall on request
    always @(posedge clk_i) begin
        if (rst_i) begin
            cmd_ready_o <= 1'b0;
        end else begin
            if (cmd_valid_i && cmd_ready_o) steps.push_back({cmd_kind_i, cmd_len_i});
            cmd_ready_o <= stall_i ? ~cmd_ready_o : 1'b1;
        end
    end
endmodule
